// *** rtl/cmd_decoder_pkg.sv ***
// Operation
// - Each command opens with an eight-byte header; for a write, data bytes follow up to the length
// - Byte 0 is the device handle; bytes 1-4 hold direction flag and 31-bit address
// - Address bit 31 set means write, clear means read; bits 30-24 pick the module
// - Address bits 7-0 pick the register; bits 23-8 are unused zeros
// - Bytes 5-7 give a 24-bit length counted in 16-bit words
// - Byte pairs form 16-bit words, first byte upper; reads go out the same way
// - Header fields arrive most significant byte first
// - A read returns two bytes for every requested word
// - Minimum influence field register reads 2 after reset until written
// - Register 15 of the neuron module returns the committed neuron count
// - Dispatch by module id 0 to 6; neuron window is registers 0x00-0x1F of module 1
package cmd_decoder_pkg;

  localparam logic [2:0] HDR_LAST_IDX = 3'h7;
  localparam logic [23:0] LEN_ZERO = 24'h000000;
  localparam logic [23:0] LEN_ONE = 24'h000001;

  localparam logic [6:0] MOD_BOARD = 7'h00;
  localparam logic [6:0] MOD_NEURON = 7'h01;
  localparam logic [6:0] MOD_SENSOR = 7'h06;
  localparam logic [7:0] NEURON_REG_LAST = 8'h1F;

  localparam logic [7:0] REG_COMP = 8'h01;
  localparam logic [7:0] REG_LAST_COMP = 8'h04;
  localparam logic [7:0] REG_MIN_IF = 8'h06;
  localparam logic [7:0] REG_MAX_IF = 8'h07;
  localparam logic [7:0] REG_NCOUNT = 8'h0F;

  localparam logic [15:0] MIN_IF_RST = 16'h0002;
  localparam logic [15:0] MAX_IF_RST = 16'h0000;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [2:0] {
    ST_HDR = 3'b000,
    ST_WHI = 3'b001,
    ST_WLO = 3'b010,
    ST_RREQ = 3'b011,
    ST_RCAP = 3'b100,
    ST_THI = 3'b101,
    ST_TLO = 3'b110
  } dec_state_t;

  typedef struct packed {
    logic [7:0] handle;
    logic wr;
    logic [6:0] module_id;
    logic [15:0] unused;
    logic [7:0] reg_id;
    logic [23:0] len;
  } cmd_hdr_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [6:0] module_id;
    logic [7:0] reg_id;
    logic [15:0] wdata;
  } ext_req_t;

  typedef struct packed {
    logic comp_valid;
    logic last_valid;
    logic [7:0] comp_data;
  } comp_strobe_t;

endpackage

// *** rtl/register_command_decoder.sv ***
`timescale 1ns/1ps
module register_command_decoder
  import cmd_decoder_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Incoming command bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  // Outgoing response bytes
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // Access port to the other on-board modules
  output ext_req_t ext_req,
  input wire logic [15:0] ext_rdata,
  // Neuron network side
  input wire logic [15:0] committed_neuron_count,
  output logic [15:0] min_influence_field,
  output logic [15:0] max_influence_field,
  output comp_strobe_t comp_strobe,
  output logic [7:0] target_device_handle,
  output logic busy
);

  // Modules served over the external access port
  function automatic logic is_ext(input logic [6:0] m);
    is_ext = (m == MOD_BOARD) || ((m > MOD_NEURON) && (m <= MOD_SENSOR));
  endfunction

  // Neuron registers held locally
  function automatic logic is_neuron(input logic [6:0] m, input logic [7:0] r);
    is_neuron = (m == MOD_NEURON) && (r <= NEURON_REG_LAST);
  endfunction

  dec_state_t state_q, state_d;
  logic [2:0] idx_q, idx_d;
  logic [55:0] shift_q, shift_d;
  cmd_hdr_t cmd_q, cmd_d;
  logic [23:0] remain_q, remain_d;
  logic [7:0] hi_q, hi_d;
  logic [7:0] lo_q, lo_d;
  logic [7:0] tx_byte_q, tx_byte_d;
  logic [15:0] min_if_q, min_if_d;
  logic [15:0] max_if_q, max_if_d;
  ext_req_t ext_q, ext_d;
  comp_strobe_t comp_q, comp_d;
  cmd_hdr_t hdr_full;
  logic [15:0] wword;
  logic [15:0] rword;

  assign hdr_full = cmd_hdr_t'({shift_q, rx_data});
  assign wword = {hi_q, rx_data};

  always_comb
  begin
    rword = WORD_ZERO;
    if (is_ext(cmd_q.module_id))
    begin
      rword = ext_rdata;
    end
    else if (is_neuron(cmd_q.module_id, cmd_q.reg_id))
    begin
      case (cmd_q.reg_id)
        REG_MIN_IF: rword = min_if_q;
        REG_MAX_IF: rword = max_if_q;
        REG_NCOUNT: rword = committed_neuron_count;
        default: rword = WORD_ZERO;
      endcase
    end
  end

  always_comb
  begin
    state_d = state_q;
    idx_d = idx_q;
    shift_d = shift_q;
    cmd_d = cmd_q;
    remain_d = remain_q;
    hi_d = hi_q;
    lo_d = lo_q;
    tx_byte_d = tx_byte_q;
    min_if_d = min_if_q;
    max_if_d = max_if_q;
    ext_d = ext_q;
    ext_d.valid = 1'b0;
    comp_d = comp_q;
    comp_d.comp_valid = 1'b0;
    comp_d.last_valid = 1'b0;
    case (state_q)
      ST_HDR:
      begin
        if (rx_valid)
        begin
          shift_d = {shift_q[47:0], rx_data};
          idx_d = idx_q + 3'h1;
          if (idx_q == HDR_LAST_IDX)
          begin
            cmd_d = hdr_full;
            remain_d = hdr_full.len;
            idx_d = 3'h0;
            if (hdr_full.len == LEN_ZERO)
            begin
              state_d = ST_HDR;
            end
            else if (hdr_full.wr)
            begin
              state_d = ST_WHI;
            end
            else
            begin
              state_d = ST_RREQ;
            end
          end
        end
      end
      ST_WHI:
      begin
        if (rx_valid)
        begin
          hi_d = rx_data;
          state_d = ST_WLO;
        end
      end
      ST_WLO:
      begin
        if (rx_valid)
        begin
          if (is_ext(cmd_q.module_id))
          begin
            ext_d.valid = 1'b1;
            ext_d.write = 1'b1;
            ext_d.module_id = cmd_q.module_id;
            ext_d.reg_id = cmd_q.reg_id;
            ext_d.wdata = wword;
          end
          else if (is_neuron(cmd_q.module_id, cmd_q.reg_id))
          begin
            case (cmd_q.reg_id)
              REG_MIN_IF: min_if_d = wword;
              REG_MAX_IF: max_if_d = wword;
              REG_COMP:
              begin
                comp_d.comp_valid = 1'b1;
                comp_d.comp_data = wword[7:0];
              end
              REG_LAST_COMP:
              begin
                comp_d.last_valid = 1'b1;
                comp_d.comp_data = wword[7:0];
              end
              default: min_if_d = min_if_q;
            endcase
          end
          remain_d = remain_q - LEN_ONE;
          state_d = (remain_q == LEN_ONE) ? ST_HDR : ST_WHI;
        end
      end
      ST_RREQ:
      begin
        if (is_ext(cmd_q.module_id))
        begin
          ext_d.valid = 1'b1;
          ext_d.write = 1'b0;
          ext_d.module_id = cmd_q.module_id;
          ext_d.reg_id = cmd_q.reg_id;
          ext_d.wdata = WORD_ZERO;
        end
        state_d = ST_RCAP;
      end
      ST_RCAP:
      begin
        tx_byte_d = rword[15:8];
        lo_d = rword[7:0];
        state_d = ST_THI;
      end
      ST_THI:
      begin
        if (tx_ready)
        begin
          tx_byte_d = lo_q;
          state_d = ST_TLO;
        end
      end
      ST_TLO:
      begin
        if (tx_ready)
        begin
          remain_d = remain_q - LEN_ONE;
          state_d = (remain_q == LEN_ONE) ? ST_HDR : ST_RREQ;
        end
      end
      default:
      begin
        state_d = ST_HDR;
        idx_d = 3'h0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= ST_HDR;
      idx_q <= 3'h0;
      shift_q <= '0;
      cmd_q <= '0;
      remain_q <= LEN_ZERO;
      hi_q <= BYTE_ZERO;
      lo_q <= BYTE_ZERO;
      tx_byte_q <= BYTE_ZERO;
      min_if_q <= MIN_IF_RST;
      max_if_q <= MAX_IF_RST;
      ext_q <= '0;
      comp_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      idx_q <= idx_d;
      shift_q <= shift_d;
      cmd_q <= cmd_d;
      remain_q <= remain_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
      tx_byte_q <= tx_byte_d;
      min_if_q <= min_if_d;
      max_if_q <= max_if_d;
      ext_q <= ext_d;
      comp_q <= comp_d;
    end
  end

  // Handshakes and outputs
  assign rx_ready = (state_q == ST_HDR) || (state_q == ST_WHI) || (state_q == ST_WLO);
  assign tx_valid = (state_q == ST_THI) || (state_q == ST_TLO);
  assign tx_data = tx_byte_q;
  assign ext_req = ext_q;
  assign comp_strobe = comp_q;
  assign min_influence_field = min_if_q;
  assign max_influence_field = max_if_q;
  assign target_device_handle = cmd_q.handle;
  assign busy = (state_q != ST_HDR) || (idx_q != 3'h0);

endmodule // register_command_decoder

// *** sim/ext_module_model.sv ***
`timescale 1ns/1ps
module ext_module_model
  import cmd_decoder_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Request and answer
  input wire ext_req_t ext_req,
  output logic [15:0] ext_rdata
);
  logic [15:0] ans;
  logic rd_now;
  logic [15:0] last_q = 16'h0000;
  assign ans = {1'b1, ext_req.module_id, ext_req.reg_id};
  assign rd_now = ext_req.valid && !ext_req.write;
  // Answer stands while the read request is raised; idle bus shows the inverse
  always @(posedge sys_clk)
  begin
    if (rd_now)
      last_q <= ans;
  end
  assign ext_rdata = rd_now ? ans : ~last_q;
endmodule // ext_module_model

// *** sim/cmd_decoder_assertions.sv ***
`timescale 1ns/1ps
module cmd_decoder_assertions
  import cmd_decoder_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Watched ports
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire ext_req_t ext_req,
  input wire logic [15:0] min_influence_field,
  input wire comp_strobe_t comp_strobe,
  input wire logic busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence ext_rd_s;
    ext_req.valid && !ext_req.write;
  endsequence
  sequence tx_wait_s;
    tx_valid && !tx_ready;
  endsequence
  valid_pulse_a: assert property (ext_req.valid |=> !ext_req.valid)
    else $error("request pulse too long");
  ext_answer_a: assert property (ext_rd_s |-> ##2 tx_valid)
    else $error("read byte late");
  tx_hold_a: assert property (tx_wait_s |=> tx_valid && $stable(tx_data))
    else $error("response byte dropped");
  rx_block_a: assert property (tx_valid |-> !rx_ready)
    else $error("input open during reply");
  idle_state_a: assert property (!busy |-> rx_ready && !tx_valid)
    else $error("idle state wrong");
  minif_write_a: assert property ($changed(min_influence_field) |-> $past(rx_valid && rx_ready))
    else $error("field changed without byte");
  comp_pulse_a: assert property (comp_strobe.comp_valid |=> !comp_strobe.comp_valid)
    else $error("component pulse too long");
  ext_route_a: assert property (ext_req.valid |-> ext_req.module_id <= MOD_SENSOR
    && ext_req.module_id != MOD_NEURON)
    else $error("bad module routed");
endmodule // cmd_decoder_assertions
bind register_command_decoder cmd_decoder_assertions u_chk (.sys_clk, .nrst, .rx_valid,
  .rx_ready, .tx_valid, .tx_data, .tx_ready, .ext_req, .min_influence_field, .comp_strobe, .busy);

// *** sim/tb_register_command_decoder.sv ***
`timescale 1ns/1ps
module tb_register_command_decoder
  import cmd_decoder_pkg::*;
;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic tx_ready = 1'b0;
  logic [15:0] ncount = 16'h0000;
  logic rx_ready, tx_valid, busy;
  logic [7:0] tx_data, handle, hexp;
  ext_req_t ext_req;
  logic [15:0] ext_rdata, minif, maxif, w;
  comp_strobe_t comp_strobe;
  integer seed = 70008;
  integer n_errors = 0;
  integer tests_run = 0;
  integer min_m = 2;
  integer max_m = 0;
  integer n_comp = 0;
  integer n_last = 0;
  integer m;
  logic [7:0] rxq[$];
  always #20 sys_clk = ~sys_clk;
  register_command_decoder dut (.sys_clk, .nrst, .rx_valid, .rx_data, .rx_ready, .tx_valid,
    .tx_data, .tx_ready, .ext_req, .ext_rdata, .committed_neuron_count(ncount),
    .min_influence_field(minif), .max_influence_field(maxif), .comp_strobe,
    .target_device_handle(handle), .busy);
  ext_module_model partner (.sys_clk, .ext_req, .ext_rdata);
  always @(posedge sys_clk) tx_ready <= ($random(seed) & 3) != 0;
  always @(negedge sys_clk)
  begin
    if (tx_valid === 1'b1 && tx_ready)
      rxq.push_back(tx_data);
    n_comp += comp_strobe.comp_valid;
    n_last += comp_strobe.last_valid;
  end
  task results;
    $display("comparisons %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask
  task send(input logic [7:0] b);
    logic ok;
    rx_valid <= 1'b1;
    rx_data <= b;
    ok = 1'b0;
    while (!ok)
    begin
      @(negedge sys_clk);
      ok = rx_ready;
      @(posedge sys_clk);
    end
  endtask
  task cmd(input logic wr, input logic [6:0] md, input logic [7:0] r, input logic [23:0] len,
    input logic [15:0] d);
    hexp = 8'($random(seed));
    send(hexp);
    send({wr, md});
    send(8'h00);
    send(8'h00);
    send(r);
    send(len[23:16]);
    send(len[15:8]);
    send(len[7:0]);
    if (wr) repeat (len)
    begin
      send(d[15:8]);
      send(d[7:0]);
    end
    rx_valid <= 1'b0;
    @(posedge sys_clk);
    if (wr && md == MOD_NEURON && r == REG_MIN_IF) min_m = d;
    if (wr && md == MOD_NEURON && r == REG_MAX_IF) max_m = d;
  endtask
  task rd(input logic [6:0] md, input logic [7:0] r, input logic [23:0] len);
    logic [15:0] e;
    logic [7:0] hi;
    integer k;
    rxq.delete();
    cmd(1'b0, md, r, len, 16'h0000);
    for (k = 0; k < 200 && rxq.size() < 2 * len; k++) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
    chk(16'(rxq.size()), 16'(2 * len));
    e = 16'h0000;
    if (md == MOD_NEURON)
      e = r == REG_MIN_IF ? 16'(min_m) : r == REG_MAX_IF ? 16'(max_m)
        : r == REG_NCOUNT ? ncount : 16'h0000;
    else if (md <= MOD_SENSOR)
      e = {1'b1, md, r};
    while (rxq.size() >= 2)
    begin
      hi = rxq.pop_front();
      chk({hi, rxq.pop_front()}, e);
    end
    chk({15'h0000, busy}, 16'h0000);
  endtask
  initial
  begin
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    ncount <= 16'($random(seed));
    @(posedge sys_clk);
    chk(minif, MIN_IF_RST);
    chk(maxif, MAX_IF_RST);
    rd(7'h01, REG_MIN_IF, 24'h000001);
    cmd(1'b1, 7'h01, REG_MAX_IF, 24'h000001, 16'h33AA);
    repeat (2) @(negedge sys_clk);
    chk(maxif, 16'h33AA);
    chk({8'h00, handle}, {8'h00, hexp});
    @(posedge sys_clk);
    cmd(1'b1, 7'h01, REG_MIN_IF, 24'h000002, 16'($random(seed)));
    rd(7'h01, REG_MIN_IF, 24'h000002);
    rd(7'h01, REG_NCOUNT, 24'h000001);
    cmd(1'b1, 7'h01, REG_COMP, 24'h000003, 16'h0009);
    cmd(1'b1, 7'h01, REG_LAST_COMP, 24'h000001, 16'h0007);
    repeat (2) @(negedge sys_clk);
    chk(16'(n_comp * 16 + n_last), 16'h0031);
    chk({8'h00, comp_strobe.comp_data}, 16'h0007);
    @(posedge sys_clk);
    for (m = 0; m < 8; m++)
    begin
      w = 16'($random(seed));
      cmd(1'b1, m[6:0], 8'h02, 24'h000001, w);
      repeat (2) @(negedge sys_clk);
      if (m != 1 && m < 7) chk(ext_req.wdata, w);
      if (m != 1 && m < 7) chk({ext_req.write, ext_req.module_id, ext_req.reg_id}, {1'b1, m[6:0], 8'h02});
      @(posedge sys_clk);
      rd(m[6:0], 8'h02, 24'h000002);
    end
    rd(7'h01, 8'h20, 24'h000001);
    rd(7'h01, REG_MIN_IF, 24'h000000);
    results;
  end
  initial
  begin
    #(40 * 30000);
    n_errors++;
    results;
  end
endmodule // tb_register_command_decoder
